// ==== logic/wwd_regs.svh ====
// Register offsets, field positions, codes and counts of the windowed watchdog
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------------
`define WWD_ADDR_W 3
`define WWD_OFS_WATCHDOG_CLEAR_REG 3'h0
`define WWD_OFS_INTERNAL_OSC_MODE_REG 3'h1
`define WWD_OFS_IRQ_STATUS 3'h2
`define WWD_OFS_IRQ_MASK 3'h3

// ----------------------------------------------------------------------------
// Codes and fields
// ----------------------------------------------------------------------------
`define WWD_DATA_W 8
`define WWD_CLEAR_CODE 8'hAC
`define WWD_READ_RUNNING 8'h9A
`define WWD_READ_PAUSED 8'h1A
`define WWD_OSC_STOP_POS 1
`define WWD_IRQ_W 3
`define WWD_IRQ_WINDOW_POS 0
`define WWD_IRQ_DEFER_POS 1
`define WWD_IRQ_CLEARED_POS 2
`define WWD_IRQ_RESET 3'h0
`define WWD_READ_NONE 8'h00

// ----------------------------------------------------------------------------
// Counter and window
// ----------------------------------------------------------------------------
`define WWD_CNT_W 12
`define WWD_CNT_MAX 12'hFFF
`define WWD_WIN_25 12'hC00
`define WWD_WIN_50 12'h800
`define WWD_WIN_75 12'h400
`define WWD_WIN_100 12'h000
`define WWD_PRE_W 7

`endif

// ==== logic/wwd_pkg.sv ====
// Types shared by the windowed watchdog modules
package wwd_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bitOp;
  } wwd_req_s;

  typedef struct packed {
    logic option_osc_keep_bit;
    logic overflow_time_select_bit2;
    logic overflow_time_select_bit1;
    logic overflow_time_select_bit0;
    logic window_size_select_hi;
    logic window_size_select_lo;
  } wwd_opt_s;

endpackage : wwd_pkg

// ==== logic/wwd_tick.sv ====
// Low-speed oscillator pin synchroniser and rising-edge tick generator
`timescale 1ns/1ps
module wwd_tick (
  input wire logic clk,
  input wire logic nrst,
  input wire logic lsClkPin,
  output logic tick
);

  logic syncA;
  logic syncB;
  logic syncC;

  // ----------------------------------------------------------------------------
  // Two-flop synchroniser, edge taken from the second and third stages only
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
      tick <= 1'b0;
    end else begin
      syncA <= lsClkPin;
      syncB <= syncA;
      syncC <= syncB;
      tick <= syncB & ~syncC;
    end
  end

endmodule : wwd_tick

// ==== logic/wwd_top.sv ====
// Windowed watchdog: low-speed counter, clear register, window check, internal reset
//
// Contract
// - Oscillator keep bit zero: counter freezes in HALT and STOP, resumes uncleared.
// - Low-speed oscillator stopped with keep bit zero: counting stops, value kept.
// - Counting continues through flash self-programming; software allows margin.
// - First clear after reset restarts the counter whenever it comes before overflow.
// - Wrong clear code resets; deferred until the source clock runs again.
// - Single-bit access to the clear register resets, deferred likewise.
// - Reading the clear register returns 9A while the source clock runs, 1A while paused, never the clear code.
// - A valid clear in the same cycle as the overflowing tick still takes effect.
`timescale 1ns/1ps
`include "wwd_regs.svh"
module wwd_top (
  input wire logic clk,
  input wire logic nrst,
  input wwd_pkg::wwd_req_s busReq,
  output logic [7:0] rdata,
  input wwd_pkg::wwd_opt_s option,
  input wire logic haltMode,
  input wire logic stopMode,
  input wire logic flashSelfProg,
  input wire logic lsClkPin,
  output logic irq,
  output logic wdtResetReq
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [`WWD_CNT_W-1:0] count;
  logic [`WWD_PRE_W-1:0] prescale;
  logic firstDone;
  logic resetPending;
  logic lowspeed_osc_stop_bit;
  logic [`WWD_IRQ_W-1:0] irqStatus;
  logic [`WWD_IRQ_W-1:0] irqMask;
  logic winOpenDly;
  logic lsTick;

  wwd_tick u_tick (
    .clk(clk),
    .nrst(nrst),
    .lsClkPin(lsClkPin),
    .tick(lsTick)
  );

  // ----------------------------------------------------------------------------
  // Source clock gating
  // ----------------------------------------------------------------------------
  wire [2:0] timeSel = {option.overflow_time_select_bit2, option.overflow_time_select_bit1,
                        option.overflow_time_select_bit0};
  wire [1:0] winSel = {option.window_size_select_hi, option.window_size_select_lo};
  wire keepOsc = option.option_osc_keep_bit;
  // The keep bit forces the oscillator on, so the stop bit only bites when it is clear
  wire oscStopped = lowspeed_osc_stop_bit & ~keepOsc;
  wire sleepFreeze = ~keepOsc & (haltMode | stopMode);
  // Flash self-programming deliberately has no term here: counting goes on
  wire srcRun = ~oscStopped & ~sleepFreeze;
  wire tickEn = lsTick & srcRun;

  // ----------------------------------------------------------------------------
  // Prescaler and window decode
  // ----------------------------------------------------------------------------
  wire [7:0] preSpan = (8'h01 << timeSel) - 8'h01;
  wire [`WWD_PRE_W-1:0] preMax = preSpan[`WWD_PRE_W-1:0];
  wire preTerm = prescale == preMax;
  wire atMax = count == `WWD_CNT_MAX;
  wire [`WWD_CNT_W-1:0] winStart = (winSel == 2'h0) ? `WWD_WIN_25 :
                                   (winSel == 2'h1) ? `WWD_WIN_50 :
                                   (winSel == 2'h2) ? `WWD_WIN_75 : `WWD_WIN_100;
  wire winOpen = count >= winStart;

  // ----------------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------------
  wire selClear = busReq.addr == `WWD_OFS_WATCHDOG_CLEAR_REG;
  wire selOsc = busReq.addr == `WWD_OFS_INTERNAL_OSC_MODE_REG;
  wire selStatus = busReq.addr == `WWD_OFS_IRQ_STATUS;
  wire selMask = busReq.addr == `WWD_OFS_IRQ_MASK;
  wire clearWrite = busReq.wr & selClear;
  wire codeOk = (busReq.wdata == `WWD_CLEAR_CODE) & ~busReq.bitOp;
  wire badAccess = clearWrite & ~codeOk;
  // Before the first clear the window is ignored; afterwards it must be open
  wire clearOk = clearWrite & codeOk & (~firstDone | winOpen);
  wire closedClear = clearWrite & codeOk & firstDone & ~winOpen;
  // A clear in the same cycle as the last tick wins over the overflow
  wire overflow = tickEn & preTerm & atMax & ~clearOk;
  wire resetEvent = badAccess | closedClear | overflow;
  wire issueReset = (resetEvent | resetPending) & srcRun;
  wire deferSet = resetEvent & ~srcRun;

  // ----------------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------------
  wire [7:0] clearRead = srcRun ? `WWD_READ_RUNNING : `WWD_READ_PAUSED;
  wire [7:0] oscRead = {6'h00, lowspeed_osc_stop_bit, 1'b0};
  wire [7:0] next_rdata = ~busReq.rd ? `WWD_READ_NONE :
                          selClear ? clearRead :
                          selOsc ? oscRead :
                          selStatus ? {5'h00, irqStatus} :
                          selMask ? {5'h00, irqMask} : `WWD_READ_NONE;

  // ----------------------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------------------
  wire [`WWD_IRQ_W-1:0] irqSet;
  assign irqSet[`WWD_IRQ_WINDOW_POS] = winOpen & ~winOpenDly & firstDone;
  assign irqSet[`WWD_IRQ_DEFER_POS] = deferSet;
  assign irqSet[`WWD_IRQ_CLEARED_POS] = clearOk;
  wire [`WWD_IRQ_W-1:0] irqClr = (busReq.wr & selStatus) ? busReq.wdata[`WWD_IRQ_W-1:0] : `WWD_IRQ_RESET;
  wire [`WWD_IRQ_W-1:0] next_irqStatus = (irqStatus & ~irqClr) | irqSet;
  wire next_irq = |(next_irqStatus & irqMask);

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      prescale <= '0;
    end else if (clearOk || issueReset) begin
      count <= '0;
      prescale <= '0;
    end else if (tickEn) begin
      prescale <= preTerm ? '0 : prescale + 7'h01;
      count <= (preTerm && !atMax) ? count + 12'h001 : count;
    end
  end

  // ----------------------------------------------------------------------------
  // First-clear tracking and deferred reset
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      firstDone <= 1'b0;
      resetPending <= 1'b0;
      wdtResetReq <= 1'b0;
    end else begin
      firstDone <= issueReset ? 1'b0 : (firstDone | clearOk);
      resetPending <= issueReset ? 1'b0 : (resetPending | deferSet);
      wdtResetReq <= issueReset;
    end
  end

  // ----------------------------------------------------------------------------
  // Software registers and outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowspeed_osc_stop_bit <= 1'b0;
      irqMask <= `WWD_IRQ_RESET;
      irqStatus <= `WWD_IRQ_RESET;
      winOpenDly <= 1'b0;
      irq <= 1'b0;
      rdata <= `WWD_READ_NONE;
    end else begin
      if (busReq.wr && selOsc) begin
        lowspeed_osc_stop_bit <= busReq.wdata[`WWD_OSC_STOP_POS];
      end
      if (busReq.wr && selMask) begin
        irqMask <= busReq.wdata[`WWD_IRQ_W-1:0];
      end
      irqStatus <= next_irqStatus;
      winOpenDly <= winOpen;
      irq <= next_irq;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  freeze_sleep_a: assert property (
    (!keepOsc && (haltMode || stopMode) && !clearWrite)
    |=> (count == $past(count)) && (prescale == $past(prescale))
  ) else $error("counter moved while frozen in halt or stop");

  osc_stop_a: assert property (
    (oscStopped && !clearWrite && !resetPending)
    |=> $stable(count) && !wdtResetReq
  ) else $error("counter moved with the low-speed oscillator stopped");

  flash_count_a: assert property (
    (flashSelfProg && tickEn && preTerm && !atMax && !clearWrite && !resetPending)
    |=> count == $past(count) + 12'h001
  ) else $error("counter did not advance during self-programming");

  first_clear_a: assert property (
    (clearWrite && codeOk && !firstDone && !resetPending)
    |=> (count == 12'h000) && firstDone && !wdtResetReq
  ) else $error("first clear after reset was not accepted");

  bad_code_a: assert property (
    (clearWrite && (busReq.wdata != `WWD_CLEAR_CODE) && srcRun)
    |=> wdtResetReq ##1 !wdtResetReq
  ) else $error("wrong clear code did not give a one-cycle reset");

  defer_reset_a: assert property (
    (badAccess && !srcRun)
    |=> resetPending && !wdtResetReq
  ) else $error("reset not deferred while the source clock is stopped");

  deferred_issue_a: assert property (
    (resetPending && srcRun) |=> wdtResetReq && !resetPending
  ) else $error("deferred reset not issued when the source clock resumed");

  bit_access_a: assert property (
    (clearWrite && busReq.bitOp && srcRun) |=> wdtResetReq
  ) else $error("single-bit access to the clear register did not reset");

  clear_read_a: assert property (
    (busReq.rd && selClear)
    |=> (rdata == `WWD_READ_RUNNING) || (rdata == `WWD_READ_PAUSED)
  ) else $error("clear register read back an unexpected value");

  late_clear_a: assert property (
    (atMax && preTerm && tickEn && clearOk && !resetPending)
    |=> (count == 12'h000) && !wdtResetReq
  ) else $error("clear just before overflow was lost");

  closed_window_a: assert property (
    (closedClear && srcRun) |=> wdtResetReq
  ) else $error("clear outside the open window did not reset");

  overflow_rst_a: assert property (
    (atMax && preTerm && tickEn && !clearWrite) |=> wdtResetReq && (count == 12'h000)
  ) else $error("overflow did not give an internal reset");

endmodule : wwd_top

// ==== testbench/tb_windowed_watchdog_timer.sv ====
// Self-checking bench for the windowed watchdog, driven through its register port
`timescale 1ns/1ps
`include "wwd_regs.svh"
module tb_windowed_watchdog_timer;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wwd_pkg::wwd_req_s busReq = '0;
  wwd_pkg::wwd_opt_s option = '0;
  logic haltMode = 1'b0;
  logic stopMode = 1'b0;
  logic flashSelfProg = 1'b0;
  logic lsClkPin = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic wdtResetReq;
  int errCount = 0;
  int testsRun = 0;
  int pulses = 0;

  always #2 clk = ~clk;

  wwd_top u_wwd_top (.clk(clk), .nrst(nrst), .busReq(busReq), .rdata(rdata), .option(option),
    .haltMode(haltMode), .stopMode(stopMode), .flashSelfProg(flashSelfProg), .lsClkPin(lsClkPin),
    .irq(irq), .wdtResetReq(wdtResetReq));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  always @(posedge clk) if (wdtResetReq === 1'b1) pulses <= pulses + 1;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic bitOp = 1'b0);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bitOp: bitOp};
    @(posedge clk);
    busReq.wr <= 1'b0;
    busReq.bitOp <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    check("rdata", rdata, exp);
  endtask : rd

  // Slow pin: the synchroniser needs a few cycles per edge, so each level lasts two
  task automatic tickN(input int n);
    repeat (n) begin
      @(posedge clk) lsClkPin <= 1'b1;
      repeat (2) @(posedge clk);
      lsClkPin <= 1'b0;
      @(posedge clk);
    end
    repeat (5) @(posedge clk);
  endtask : tickN

  task automatic pulsesAre(input int n);
    repeat (4) @(posedge clk);
    check("resets", 8'(pulses), 8'(n));
  endtask : pulsesAre

  task automatic tallyAndFinish;
    $display("Checks %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    #360000;
    errCount++;
    tallyAndFinish();
  end

  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial begin
    // Overflow select 0 with a 75% window, never the forbidden all-zero pairing
    option <= '{option_osc_keep_bit: 1'b0, overflow_time_select_bit2: 1'b0, overflow_time_select_bit1: 1'b0,
      overflow_time_select_bit0: 1'b0, window_size_select_hi: 1'b1, window_size_select_lo: 1'b0};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_READ_RUNNING);
    rd(`WWD_OFS_IRQ_STATUS, 8'h00);
    rd(`WWD_OFS_IRQ_MASK, 8'h00);
    rd(3'h5, `WWD_READ_NONE);
    wr(`WWD_OFS_IRQ_MASK, 8'h07);
    tickN(8);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    pulsesAre(0);
    rd(`WWD_OFS_IRQ_STATUS, 8'h04);
    check("irq", {7'h00, irq}, 8'h01);
    wr(`WWD_OFS_IRQ_STATUS, 8'h04);
    rd(`WWD_OFS_IRQ_STATUS, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    pulsesAre(1);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, 8'h55);
    pulsesAre(2);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE, 1'b1);
    pulsesAre(3);
    // Faults while the source clock is stopped wait for it to resume
    wr(`WWD_OFS_INTERNAL_OSC_MODE_REG, 8'h02);
    rd(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_READ_PAUSED);
    rd(`WWD_OFS_INTERNAL_OSC_MODE_REG, 8'h02);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, 8'h55);
    pulsesAre(3);
    rd(`WWD_OFS_IRQ_STATUS, 8'h02);
    check("irq", {7'h00, irq}, 8'h01);
    wr(`WWD_OFS_IRQ_MASK, 8'h05);
    // The interrupt flop follows the new mask one edge after the write lands
    @(posedge clk);
    #1;
    check("irq", {7'h00, irq}, 8'h00);
    wr(`WWD_OFS_IRQ_MASK, 8'h07);
    wr(`WWD_OFS_INTERNAL_OSC_MODE_REG, 8'h00);
    pulsesAre(4);
    wr(`WWD_OFS_IRQ_STATUS, 8'h07);
    // Window-open flag shows exactly when the frozen count reaches 400
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    wr(`WWD_OFS_IRQ_STATUS, 8'h07);
    tickN(12'h3FE);
    wr(`WWD_OFS_INTERNAL_OSC_MODE_REG, 8'h02);
    tickN(5);
    wr(`WWD_OFS_INTERNAL_OSC_MODE_REG, 8'h00);
    tickN(1);
    rd(`WWD_OFS_IRQ_STATUS, 8'h00);
    haltMode <= 1'b1;
    tickN(5);
    haltMode <= 1'b0;
    stopMode <= 1'b1;
    tickN(5);
    stopMode <= 1'b0;
    rd(`WWD_OFS_IRQ_STATUS, 8'h00);
    tickN(1);
    rd(`WWD_OFS_IRQ_STATUS, 8'h01);
    flashSelfProg <= 1'b1;
    tickN(16);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    pulsesAre(4);
    tickN(12'hFFF);
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    pulsesAre(4);
    tickN(12'hFFF);
    pulsesAre(4);
    // Clear strobe lands on the very edge of the overflowing tick
    @(posedge clk) lsClkPin <= 1'b1;
    repeat (2) @(posedge clk);
    lsClkPin <= 1'b0;
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    pulsesAre(4);
    tickN(12'hFFF);
    pulsesAre(4);
    tickN(1);
    pulsesAre(5);
    // Keep bit set: halt and the stop bit no longer hold the count; prescaler halves the rate
    option <= '{option_osc_keep_bit: 1'b1, overflow_time_select_bit2: 1'b0, overflow_time_select_bit1: 1'b0,
      overflow_time_select_bit0: 1'b1, window_size_select_hi: 1'b1, window_size_select_lo: 1'b0};
    wr(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_CLEAR_CODE);
    wr(`WWD_OFS_INTERNAL_OSC_MODE_REG, 8'h02);
    wr(`WWD_OFS_IRQ_STATUS, 8'h07);
    haltMode <= 1'b1;
    rd(`WWD_OFS_WATCHDOG_CLEAR_REG, `WWD_READ_RUNNING);
    tickN(12'h7FF);
    rd(`WWD_OFS_IRQ_STATUS, 8'h00);
    tickN(1);
    rd(`WWD_OFS_IRQ_STATUS, 8'h01);
    tallyAndFinish();
  end
endmodule : tb_windowed_watchdog_timer
